// ==== verilog/ohb_host_bus.sv ====
// host bus interface of the display controller: parallel and serial links
`timescale 1ns/1ps
`default_nettype none
`include "ohb_defines.svh"
module ohb_host_bus (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // host link pins
    input  wire logic       chip_sel_n,
    input  wire logic       data_cmd,
    input  wire logic       enable_read,
    input  wire logic       dir_write,
    input  wire logic       power_on_init_n,
    input  wire logic       protocol_strap_low,
    input  wire logic       protocol_strap_high,
    // host byte bus, split into three signals
    input  wire logic [7:0] host_byte_bus_in,
    output logic [7:0]      host_byte_bus_out,
    output logic            host_byte_bus_oe,
    // core side: received bytes
    output logic            wr_valid,
    output logic [7:0]      wr_byte,
    output logic            wr_is_data,
    // core side: read data source
    input  wire logic [7:0] rd_byte,
    output logic            rd_strobe,
    output logic            rd_is_data,
    // core side: initialisation in progress
    output logic            init_active
);
    ohb_pkg::ohb_proto_e proto;        // strap-selected protocol
    ohb_pkg::ohb_proto_e next_proto;
    logic       strobe_prev;           // last strobe level (active high)
    logic       next_strobe_prev;
    logic       next_wr_valid;
    logic [7:0] next_wr_byte;
    logic       next_wr_is_data;
    logic [7:0] next_bus_out;
    logic       next_bus_oe;
    logic       next_rd_strobe;
    logic       next_rd_is_data;
    logic       next_init;
    logic       par_act;               // strobe asserted, parallel modes
    logic       par_read;              // asserted strobe is a read
    logic       ser_valid;
    logic [7:0] ser_byte;
    logic       ser_is_data;
    logic       ser_active;
    logic       selected;

    // strap decode; straps are static so plain sampling is enough
    function automatic ohb_pkg::ohb_proto_e decode(input logic [1:0] s);
        unique case (s)
            `OHB_STRAP_SINGLE: decode = ohb_pkg::OHB_SINGLE;
            `OHB_STRAP_SPLIT:  decode = ohb_pkg::OHB_SPLIT;
            `OHB_STRAP_SER3:   decode = ohb_pkg::OHB_SER3;
            default:           decode = ohb_pkg::OHB_SER4;
        endcase
    endfunction : decode

    // serial receiver taps bus bits 1 and 0
    assign ser_active = selected && !init_active &&
        (proto == ohb_pkg::OHB_SER3 || proto == ohb_pkg::OHB_SER4);

    ohb_serial_rx ohb_serial_rx_i (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .active         (ser_active),
        // clock on bit 0, data on bit 1
        .clk_line       (host_byte_bus_in[`OHB_SER_CLK_BIT]),
        .serial_in_line (host_byte_bus_in[`OHB_SER_DATA_BIT]),
        .dc_line        (data_cmd),
        .byte_valid     (ser_valid),
        .byte_data      (ser_byte),
        .byte_is_data   (ser_is_data)
    );

    // next values for strobe decode, bus driving and core handoff
    always_comb begin
        selected = ~chip_sel_n;
        par_act  = 1'b0;
        par_read = 1'b0;
        unique case (proto)
            ohb_pkg::OHB_SINGLE: begin
                par_act  = enable_read;
                par_read = dir_write;
            end
            ohb_pkg::OHB_SPLIT: begin
                par_act  = ~enable_read | ~dir_write;
                par_read = ~enable_read;
            end
            default: begin
                // serial modes: strobes are grounded by the host
                par_act  = 1'b0;
                par_read = 1'b0;
            end
        endcase
        par_act = par_act & selected & ~init_active;
        next_init        = ~power_on_init_n;
        next_proto       = init_active ?
            decode({protocol_strap_high, protocol_strap_low}) : proto;
        next_strobe_prev = par_act;
        next_wr_valid    = 1'b0;
        next_wr_byte     = wr_byte;
        next_wr_is_data  = wr_is_data;
        next_rd_strobe   = 1'b0;
        next_rd_is_data  = rd_is_data;
        next_bus_out     = host_byte_bus_out;
        // drive bus while a read strobe stands
        next_bus_oe      = par_act & par_read;
        if (par_act && !strobe_prev) begin
            if (par_read) begin
                next_bus_out    = rd_byte;
                next_rd_strobe  = 1'b1;
                next_rd_is_data = data_cmd;
            end else begin
                next_wr_valid   = 1'b1;
                next_wr_byte    = host_byte_bus_in;
                next_wr_is_data = data_cmd;
            end
        end else if (ser_valid) begin
            // serial byte; in three-wire mode data_cmd is low
            next_wr_valid   = 1'b1;
            next_wr_byte    = ser_byte;
            next_wr_is_data = ser_is_data;
        end
    end

    // registers only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            proto             <= ohb_pkg::OHB_SINGLE;
            strobe_prev       <= 1'b0;
            wr_valid          <= 1'b0;
            wr_byte           <= `OHB_BYTE_RST;
            wr_is_data        <= 1'b0;
            rd_strobe         <= 1'b0;
            rd_is_data        <= 1'b0;
            host_byte_bus_out <= `OHB_BYTE_RST;
            host_byte_bus_oe  <= 1'b0;
            init_active       <= 1'b1;
        end else begin
            proto             <= next_proto;
            strobe_prev       <= next_strobe_prev;
            wr_valid          <= next_wr_valid;
            wr_byte           <= next_wr_byte;
            wr_is_data        <= next_wr_is_data;
            rd_strobe         <= next_rd_strobe;
            rd_is_data        <= next_rd_is_data;
            host_byte_bus_out <= next_bus_out;
            host_byte_bus_oe  <= next_bus_oe;
            init_active       <= next_init;
        end
    end

    // a parallel write pulse follows the rising of the active strobe
    sequence s_par_start;
        !strobe_prev && par_act && !par_read;
    endsequence
    // a parallel read starts on the same rising, direction read
    sequence s_rd_start;
        !strobe_prev && par_act && par_read;
    endsequence
    // pin-level starts; written from the pins so that a broken
    // strobe decode above cannot hide behind its own signals
    sequence s_single_rd_pins;
        proto == ohb_pkg::OHB_SINGLE && !chip_sel_n && !init_active
        && enable_read && dir_write && !strobe_prev;
    endsequence
    sequence s_split_wr_pins;
        proto == ohb_pkg::OHB_SPLIT && !chip_sel_n && !init_active
        && enable_read && !dir_write && !strobe_prev;
    endsequence
    a_write_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_par_start |=> wr_valid && wr_byte == $past(host_byte_bus_in))
        else $error("write strobe gave no byte");
    a_single_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_single_rd_pins |=> rd_strobe && host_byte_bus_oe
        && host_byte_bus_out == $past(rd_byte))
        else $error("single strobe read did not start");
    a_split_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        proto == ohb_pkg::OHB_SPLIT && !chip_sel_n && !init_active
        && !enable_read |=> host_byte_bus_oe)
        else $error("split read did not drive bus");
    a_split_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_split_wr_pins |=> wr_valid && wr_byte == $past(host_byte_bus_in))
        else $error("split write strobe gave no byte");
    a_bus_drive: assert property (
        @(posedge ref_clk) disable iff (rst)
        host_byte_bus_oe |-> $past(par_read) && $past(par_act))
        else $error("bus driven outside read");
    a_dc_route: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_par_start |=> wr_is_data == $past(data_cmd))
        else $error("data/command not routed");
    a_rd_route: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_rd_start |=> rd_is_data == $past(data_cmd))
        else $error("read data/command not kept");
    a_cs_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        chip_sel_n |=> !host_byte_bus_oe && !rd_strobe)
        else $error("activity while deselected");
    a_init_hold: assert property (
        @(posedge ref_clk) disable iff (rst)
        !power_on_init_n |=> init_active ##1 !wr_valid)
        else $error("activity during initialisation");
    // initialisation also keeps the bus released and reads quiet
    a_init_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        init_active |=> !rd_strobe && !host_byte_bus_oe)
        else $error("read during initialisation");
endmodule : ohb_host_bus
`default_nettype wire

// ==== verilog/ohb_defines.svh ====
// constants for the host bus interface of the display controller
`ifndef OHB_DEFINES_SVH
`define OHB_DEFINES_SVH
// protocol strap codes {high,low}; the encoding is a free choice here
`define OHB_STRAP_SINGLE 2'h0
`define OHB_STRAP_SPLIT  2'h1
`define OHB_STRAP_SER3   2'h2
`define OHB_STRAP_SER4   2'h3
// serial data line and clock line positions on the byte bus
`define OHB_SER_DATA_BIT 1
`define OHB_SER_CLK_BIT  0
// reset values
`define OHB_BYTE_RST     8'h00
`define OHB_CNT_RST      3'h0
`endif

// ==== verilog/ohb_pkg.sv ====
// types shared by the host bus interface files
`default_nettype none
package ohb_pkg;
    // link protocol selected by the straps
    typedef enum logic [3:0] {
        OHB_SINGLE = 4'h1,
        OHB_SPLIT  = 4'h2,
        OHB_SER3   = 4'h4,
        OHB_SER4   = 4'h8
    } ohb_proto_e;
endpackage : ohb_pkg
`default_nettype wire

// ==== verilog/ohb_serial_rx.sv ====
// serial shift receiver: eight rising clock edges make one byte
`timescale 1ns/1ps
`default_nettype none
`include "ohb_defines.svh"
module ohb_serial_rx (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // link lines
    input  wire logic       active,
    input  wire logic       clk_line,
    input  wire logic       serial_in_line,
    input  wire logic       dc_line,
    // received byte
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            byte_is_data
);
    logic       clk_prev;      // last sampled serial clock
    logic [2:0] bit_cnt;       // bits taken so far
    logic [7:0] shreg;         // shift register, msb first
    logic       next_clk_prev;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_shreg;
    logic       next_valid;
    logic [7:0] next_data;
    logic       next_is_data;
    logic       rise;

    // next state: sample on rising serial clock
    always_comb begin
        rise          = clk_line & ~clk_prev;
        next_clk_prev = clk_line;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_valid    = 1'b0;
        next_data     = byte_data;
        next_is_data  = byte_is_data;
        if (!active) begin
            // deselect drops a partial byte
            next_bit_cnt = `OHB_CNT_RST;
        end else if (rise) begin
            next_shreg   = {shreg[6:0], serial_in_line};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                // byte done; data/command sampled with the last bit
                next_valid   = 1'b1;
                next_data    = {shreg[6:0], serial_in_line};
                next_is_data = dc_line;
            end
        end
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_prev     <= 1'b0;
            bit_cnt      <= `OHB_CNT_RST;
            shreg        <= `OHB_BYTE_RST;
            byte_valid   <= 1'b0;
            byte_data    <= `OHB_BYTE_RST;
            byte_is_data <= 1'b0;
        end else begin
            clk_prev     <= next_clk_prev;
            bit_cnt      <= next_bit_cnt;
            shreg        <= next_shreg;
            byte_valid   <= next_valid;
            byte_data    <= next_data;
            byte_is_data <= next_is_data;
        end
    end

    // a byte is flagged only after an eighth bit
    a_byte_count: assert property (
        @(posedge ref_clk) disable iff (rst)
        byte_valid |-> $past(bit_cnt) == 3'h7)
        else $error("serial byte without eight bits");
    // deselect leaves no partial byte behind
    a_drop_partial: assert property (
        @(posedge ref_clk) disable iff (rst)
        !active |=> bit_cnt == `OHB_CNT_RST)
        else $error("partial serial byte kept");
endmodule : ohb_serial_rx
`default_nettype wire

// ==== tb/ohb_host_model.sv ====
// host microcontroller model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module ohb_host_model (
    // clock
    input  wire logic       ref_clk,
    // host pins
    output logic            chip_sel_n,
    output logic            data_cmd,
    output logic            enable_read,
    output logic            dir_write,
    output logic            power_on_init_n,
    output logic [1:0]      strap,
    output logic [7:0]      drive
);
    logic split;  // split-strobe protocol
    initial begin
        {chip_sel_n, power_on_init_n} = 2'h3;
        {data_cmd, enable_read, dir_write, split} = 4'h0;
        {strap, drive} = 10'h000;
    end
    task automatic set_mode(input logic [1:0] code);
        @(negedge ref_clk);
        power_on_init_n = 1'b0;
        strap = code;
        split = (code == 2'h1);
        {enable_read, dir_write, data_cmd} = {split, split, 1'b0};
        drive = 8'h00;
        repeat (3) @(negedge ref_clk);
        power_on_init_n = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask : set_mode
    task automatic strobe(input logic on, rd, cs_n, dc, input logic [7:0] b);
        @(negedge ref_clk);
        chip_sel_n = on ? cs_n : 1'b1;
        data_cmd = dc;
        // released lines never keep the last byte
        drive = (on && !rd) ? b : ~b;
        enable_read = split ? !(on && rd) : on;
        dir_write = split ? !(on && !rd) : rd;
    endtask : strobe
    // clock bit 0, data bit 1, rest low
    task automatic ser_bits(input logic [7:0] b, input logic dc, input int n);
        @(negedge ref_clk);
        chip_sel_n = 1'b0;
        data_cmd = dc;
        for (int i = 7; i > 7 - n; i--) begin
            drive = {6'h00, b[i], 1'b0};
            repeat (3) @(negedge ref_clk);
            drive[0] = 1'b1;
            repeat (3) @(negedge ref_clk);
        end
        // clock stands low, data flips
        drive = {6'h00, ~b[8 - n], 1'b0};
        chip_sel_n = 1'b1;
    endtask : ser_bits
endmodule : ohb_host_model
`default_nettype wire

// ==== tb/oled_host_bus_interface_test.sv ====
// self-checking bench for the host bus interface
`timescale 1ns/1ps
`default_nettype none
module oled_host_bus_interface_test;
    logic       ref_clk = 1'b0;  // 40 MHz
    logic       rst = 1'b1;      // sync reset
    logic [7:0] rd_byte = 8'h00; // core read data
    int         fail_count = 0;
    int         n_compared = 0;
    int         cycles = 0;      // hang guard
    wire logic  cs_n, dc, en_rd, dir_wr, init_n, oe, wr_valid;
    wire logic  wr_is_data, rd_strobe, rd_is_data, init_active;
    wire logic [1:0] strap;
    wire logic [7:0] drive, bus_out, wr_byte;
    // device wins the bus while it drives
    wire logic [7:0] bus_in = oe ? bus_out : drive;
    always #12.5 ref_clk = ~ref_clk;
    ohb_host_model ohb_host_model_i (
        .ref_clk(ref_clk), .chip_sel_n(cs_n), .data_cmd(dc),
        .enable_read(en_rd), .dir_write(dir_wr), .power_on_init_n(init_n),
        .strap(strap), .drive(drive)
    );
    ohb_host_bus ohb_host_bus_i (
        .ref_clk(ref_clk), .rst(rst), .chip_sel_n(cs_n), .data_cmd(dc),
        .enable_read(en_rd), .dir_write(dir_wr), .power_on_init_n(init_n),
        .protocol_strap_low(strap[0]), .protocol_strap_high(strap[1]),
        .host_byte_bus_in(bus_in), .host_byte_bus_out(bus_out),
        .host_byte_bus_oe(oe), .wr_valid(wr_valid), .wr_byte(wr_byte),
        .wr_is_data(wr_is_data), .rd_byte(rd_byte),
        .rd_strobe(rd_strobe),
        .rd_is_data(rd_is_data), .init_active(init_active)
    );
    task automatic check(input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // bounded watch for a one-cycle pulse, sampled mid-cycle
    task automatic wait_pulse(input bit rd, input int lim, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge ref_clk);
            hit = rd ? (rd_strobe === 1'b1) : (wr_valid === 1'b1);
        end
    endtask : wait_pulse
    task automatic do_write(input logic [7:0] b, input logic dcv, cs);
        bit hit;
        ohb_host_model_i.strobe(1'b1, 1'b0, cs, dcv, b);
        wait_pulse(1'b0, 4, hit);
        check(hit, !cs);
        if (hit) check(wr_byte, b);
        if (hit) check(wr_is_data, dcv);
        ohb_host_model_i.strobe(1'b0, 1'b0, cs, dcv, b);
    endtask : do_write
    task automatic do_read(input logic [7:0] b, input logic dcv);
        bit hit;
        rd_byte = b;
        ohb_host_model_i.strobe(1'b1, 1'b1, 1'b0, dcv, b);
        wait_pulse(1'b1, 4, hit);
        check(hit, 1'b1);
        @(negedge ref_clk);
        check(oe, 1'b1);
        check(bus_in, b);
        check(rd_is_data, dcv);
        ohb_host_model_i.strobe(1'b0, 1'b1, 1'b0, dcv, b);
        repeat (2) @(negedge ref_clk);
        check(oe, 1'b0);
    endtask : do_read
    task automatic do_ser(input logic [7:0] b, input logic dcv, input int n);
        bit hit;
        fork
            ohb_host_model_i.ser_bits(b, dcv, n);
            wait_pulse(1'b0, 8 * n, hit);
        join
        check(hit, n == 8);
        if (hit) check(wr_byte, b);
        if (hit && strap == 2'h3) check(wr_is_data, dcv);
    endtask : do_ser
    // single strobe, entered through a fresh initialisation
    task automatic t_single;
        fork
            ohb_host_model_i.set_mode(2'h0);
            begin
                repeat (3) @(negedge ref_clk);
                check(init_active, 1'b1);
            end
        join
        check(init_active, 1'b0);
        do_write(8'hA5, 1'b1, 1'b0);
        do_write(8'h5A, 1'b0, 1'b0);
        do_write(8'h77, 1'b1, 1'b1);
        do_read(8'hC3, 1'b1);
        do_read(8'h3C, 1'b0);
    endtask : t_single
    task automatic t_split;
        ohb_host_model_i.set_mode(2'h1);
        do_write(8'h81, 1'b0, 1'b0);
        do_write(8'h18, 1'b1, 1'b1);
        do_read(8'h7E, 1'b1);
    endtask : t_split
    // partial byte dropped on deselect, then whole bytes
    task automatic t_serial;
        ohb_host_model_i.set_mode(2'h3);
        do_ser(8'hF0, 1'b1, 4);
        do_ser(8'h96, 1'b1, 8);
        do_ser(8'h69, 1'b0, 8);
        ohb_host_model_i.set_mode(2'h2);
        do_ser(8'hB4, 1'b0, 8);
    endtask : t_serial
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        check(init_active, 1'b1);
        check(oe, 1'b0);
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        t_single();
        t_split();
        t_serial();
        close_out();
    end
endmodule : oled_host_bus_interface_test
`default_nettype wire
